// [hw/sstc_defines.vh]
// Shared bit positions, reset values and timing counts for the self-test trigger block
`ifndef SSTC_DEFINES_VH
`define SSTC_DEFINES_VH

// ----------------------------------------
// Control register layout
// ----------------------------------------
`define SSTC_REG_W 16
`define SSTC_REG_RESET 16'h0000
`define SSTC_BIT_SC_CHK 8
`define SSTC_BIT_OC_CHK 7
`define SSTC_BIT_RSVD6 6
`define SSTC_BIT_GATE_THRESHOLD_VOLTAGE 5
`define SSTC_BIT_RSVD4 4
`define SSTC_BIT_CLK_CHK 3
`define SSTC_BIT_CRC_CHK 2
// Bits of the register this block owns
`define SSTC_OWNED_MASK 16'h01FC
// Command bits that clear themselves once carried out
`define SSTC_SELF_CLR_MASK 16'h01AC

// ----------------------------------------
// Configuration and timing
// ----------------------------------------
`define SSTC_CFG_W 2
`define SSTC_CFG_TWO 2'h2
`define SSTC_GATE_THRESHOLD_VOLTAGE_CYC 16'h0010
`define SSTC_CRC_W 16
`define SSTC_CRC_POLY 16'h1021
`define SSTC_CRC_SEED 16'hFFFF

`endif

// [hw/sstc_crc_engine.v]
// Serial CRC over the secondary-side configuration word
`timescale 1ns/10ps
`default_nettype none
`include "sstc_defines.vh"

module sstc_crc_engine #(
	parameter CFG_W = 32,
	parameter CRC_W = `SSTC_CRC_W
) (
	// Clock, reset, enable
	input wire mclk_in,
	input wire rst_in,
	input wire ce_in,
	// Control
	input wire start_in,
	input wire [CFG_W-1:0] cfg_bits_in,
	input wire [CRC_W-1:0] expect_in,
	// Result
	output reg done_out,
	output reg mismatch_out
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [CFG_W-1:0] shift_r; // Bits still to fold in
	reg [CRC_W-1:0] crc_r; // Running remainder
	reg [7:0] cnt_r; // Bits remaining
	reg busy_r; // Walk in progress
	wire fb; // Feedback bit

	assign fb = crc_r[CRC_W-1] ^ shift_r[CFG_W-1];

	// ----------------------------------------
	// One bit per enabled cycle, MSB first
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (rst_in) begin
			shift_r <= {CFG_W{1'b0}};
			crc_r <= `SSTC_CRC_SEED;
			cnt_r <= 8'h00;
			busy_r <= 1'b0;
			done_out <= 1'b0;
			mismatch_out <= 1'b0;
		end else if (ce_in) begin
			done_out <= 1'b0;
			if (start_in && !busy_r && !done_out) begin
				// Load a fresh snapshot; the done cycle blocks a stale restart
				shift_r <= cfg_bits_in;
				crc_r <= `SSTC_CRC_SEED;
				cnt_r <= CFG_W[7:0];
				busy_r <= 1'b1;
			end else if (busy_r) begin
				if (cnt_r == 8'h00) begin
					// Compare against stored value
					busy_r <= 1'b0;
					done_out <= 1'b1;
					mismatch_out <= (crc_r != expect_in);
				end else begin
					shift_r <= {shift_r[CFG_W-2:0], 1'b0};
					crc_r <= {crc_r[CRC_W-2:0], 1'b0} ^ (fb ? `SSTC_CRC_POLY : {CRC_W{1'b0}});
					cnt_r <= cnt_r - 8'h01;
				end
			end
		end
	end

endmodule
`default_nettype wire

// [hw/sstc_top.v]
// Secondary-side self-test triggers of the gate driver control register
// Overview of operation
// - Short-circuit check bit forces trip, sets fault
// - Overcurrent check bit forces trip, sets fault
// - Bit 5 starts threshold measure, configuration two
// - Bit 3 forces secondary clock monitor fault
// - Serial interface keeps running during clock test
// - Bit 2 runs secondary config CRC, sets fault
`timescale 1ns/10ps
`default_nettype none
`include "sstc_defines.vh"

module sstc_top #(
	parameter CFG_W = 32,
	parameter GATE_THRESHOLD_VOLTAGE_CYC = `SSTC_GATE_THRESHOLD_VOLTAGE_CYC
) (
	// Clock, reset, enable
	input wire mclk_in,
	input wire rst_in,
	input wire ce_in,
	// Register port from the serial configuration interface
	input wire reg_wr_in,
	input wire [`SSTC_REG_W-1:0] reg_wdata_in,
	output reg [`SSTC_REG_W-1:0] reg_rdata_out,
	// Device state, same clock domain
	input wire active_mode_in,
	input wire config_crc_disable_in,
	input wire [`SSTC_CFG_W-1:0] config_sel_in,
	input wire high_side_output_in,
	input wire status_clear_in,
	// Comparator and monitor inputs from the analog side (asynchronous)
	input wire sc_cmp_in,
	input wire oc_cmp_in,
	input wire clk_mon_fail_in,
	// Configuration image and stored CRC
	input wire [CFG_W-1:0] sec_cfg_bits_in,
	input wire [`SSTC_CRC_W-1:0] sec_cfg_crc_in,
	// Forced trip drives to the comparators
	output reg sc_force_trip_out,
	output reg oc_force_trip_out,
	output reg clk_mon_force_out,
	// Threshold measurement
	output reg gate_threshold_measure_out,
	// Fault flags
	output reg short_circuit_fault_flag_out,
	output reg overcurrent_fault_flag_out,
	output reg sec_clock_monitor_fault_flag_out,
	output reg sec_config_crc_fault_flag_out,
	// Serial interface keeps running
	output reg spi_keep_alive_out
);

	// ----------------------------------------
	// Synchronisers for analog inputs
	// ----------------------------------------
	reg [2:0] async_s1_r; // First stage, read only by second
	reg [2:0] async_s2_r; // Second stage
	always @(posedge mclk_in) begin
		if (rst_in) begin
			async_s1_r <= 3'h0;
			async_s2_r <= 3'h0;
		end else if (ce_in) begin
			async_s1_r <= {clk_mon_fail_in, oc_cmp_in, sc_cmp_in};
			async_s2_r <= async_s1_r;
		end
	end

	// ----------------------------------------
	// Control register bits
	// ----------------------------------------
	reg [`SSTC_REG_W-1:0] ctrl_r; // Owned bits of the control register
	reg [`SSTC_REG_W-1:0] ctrl_nxt; // Next value
	reg [15:0] gate_threshold_voltage_cnt_r; // Measurement window count
	reg gate_threshold_voltage_busy_r; // Measurement running
	wire crc_done; // CRC walk finished
	wire crc_bad; // CRC disagreed
	wire wr_sc; // Short-circuit check written
	wire wr_oc; // Overcurrent check written
	wire wr_gate_threshold_voltage; // Threshold measure written
	wire wr_clk; // Clock monitor check written
	wire wr_crc; // CRC check written
	wire cfg_two; // Device in configuration two

	assign wr_sc = reg_wr_in & reg_wdata_in[`SSTC_BIT_SC_CHK];
	assign wr_oc = reg_wr_in & reg_wdata_in[`SSTC_BIT_OC_CHK];
	assign wr_gate_threshold_voltage = reg_wr_in & reg_wdata_in[`SSTC_BIT_GATE_THRESHOLD_VOLTAGE];
	assign wr_clk = reg_wr_in & reg_wdata_in[`SSTC_BIT_CLK_CHK];
	assign wr_crc = reg_wr_in & reg_wdata_in[`SSTC_BIT_CRC_CHK];
	assign cfg_two = (config_sel_in == `SSTC_CFG_TWO);

	// Next register value: reserved bits store, commands clear when done
	always @* begin
		ctrl_nxt = ctrl_r;
		if (reg_wr_in) begin
			// Reserved bits keep what was written
			ctrl_nxt = reg_wdata_in & `SSTC_OWNED_MASK;
			ctrl_nxt = ctrl_nxt & ~`SSTC_SELF_CLR_MASK;
			ctrl_nxt = ctrl_nxt | (ctrl_r & `SSTC_SELF_CLR_MASK);
			ctrl_nxt[`SSTC_BIT_SC_CHK] = wr_sc | ctrl_r[`SSTC_BIT_SC_CHK];
			ctrl_nxt[`SSTC_BIT_OC_CHK] = wr_oc | ctrl_r[`SSTC_BIT_OC_CHK];
			ctrl_nxt[`SSTC_BIT_GATE_THRESHOLD_VOLTAGE] = (wr_gate_threshold_voltage & cfg_two) | ctrl_r[`SSTC_BIT_GATE_THRESHOLD_VOLTAGE];
			ctrl_nxt[`SSTC_BIT_CLK_CHK] = wr_clk | ctrl_r[`SSTC_BIT_CLK_CHK];
			ctrl_nxt[`SSTC_BIT_CRC_CHK] = wr_crc | ctrl_r[`SSTC_BIT_CRC_CHK];
		end
		// Trip and clock checks complete once the fault flag is seen, the CRC check once crc_done is seen
		if (ctrl_r[`SSTC_BIT_SC_CHK] && short_circuit_fault_flag_out && !wr_sc) begin
			ctrl_nxt[`SSTC_BIT_SC_CHK] = 1'b0;
		end
		if (ctrl_r[`SSTC_BIT_OC_CHK] && overcurrent_fault_flag_out && !wr_oc) begin
			ctrl_nxt[`SSTC_BIT_OC_CHK] = 1'b0;
		end
		if (ctrl_r[`SSTC_BIT_CLK_CHK] && sec_clock_monitor_fault_flag_out && !wr_clk) begin
			ctrl_nxt[`SSTC_BIT_CLK_CHK] = 1'b0;
		end
		if (ctrl_r[`SSTC_BIT_CRC_CHK] && crc_done && !wr_crc) begin
			ctrl_nxt[`SSTC_BIT_CRC_CHK] = 1'b0;
		end
		// A fresh accepted request in the last window cycle survives
		if (gate_threshold_voltage_busy_r && gate_threshold_voltage_cnt_r == 16'h0001 && !(wr_gate_threshold_voltage && cfg_two)) begin
			ctrl_nxt[`SSTC_BIT_GATE_THRESHOLD_VOLTAGE] = 1'b0;
		end
	end

	// Register update
	always @(posedge mclk_in) begin
		if (rst_in) begin
			ctrl_r <= `SSTC_REG_RESET;
		end else if (ce_in) begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ----------------------------------------
	// Threshold measurement window
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (rst_in) begin
			gate_threshold_voltage_cnt_r <= 16'h0000;
			gate_threshold_voltage_busy_r <= 1'b0;
			gate_threshold_measure_out <= 1'b0;
		end else if (ce_in) begin
			if (!gate_threshold_voltage_busy_r && ctrl_r[`SSTC_BIT_GATE_THRESHOLD_VOLTAGE] && cfg_two) begin
				// Start only in configuration two
				gate_threshold_voltage_busy_r <= 1'b1;
				gate_threshold_voltage_cnt_r <= GATE_THRESHOLD_VOLTAGE_CYC[15:0];
				gate_threshold_measure_out <= 1'b1;
			end else if (gate_threshold_voltage_busy_r) begin
				if (gate_threshold_voltage_cnt_r == 16'h0001) begin
					gate_threshold_voltage_busy_r <= 1'b0;
					gate_threshold_measure_out <= 1'b0;
				end
				gate_threshold_voltage_cnt_r <= gate_threshold_voltage_cnt_r - 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Secondary configuration CRC
	// ----------------------------------------
	sstc_crc_engine #(
		.CFG_W(CFG_W),
		.CRC_W(`SSTC_CRC_W)
	) u_crc (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.start_in(ctrl_r[`SSTC_BIT_CRC_CHK]),
		.cfg_bits_in(sec_cfg_bits_in),
		.expect_in(sec_cfg_crc_in),
		.done_out(crc_done),
		.mismatch_out(crc_bad)
	);

	// ----------------------------------------
	// Forced trips and fault flags
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (rst_in) begin
			sc_force_trip_out <= 1'b0;
			oc_force_trip_out <= 1'b0;
			clk_mon_force_out <= 1'b0;
			short_circuit_fault_flag_out <= 1'b0;
			overcurrent_fault_flag_out <= 1'b0;
			sec_clock_monitor_fault_flag_out <= 1'b0;
			sec_config_crc_fault_flag_out <= 1'b0;
			spi_keep_alive_out <= 1'b1;
		end else if (ce_in) begin
			// Force comparators while the check is pending
			sc_force_trip_out <= ctrl_r[`SSTC_BIT_SC_CHK];
			oc_force_trip_out <= ctrl_r[`SSTC_BIT_OC_CHK];
			clk_mon_force_out <= ctrl_r[`SSTC_BIT_CLK_CHK];
			// Serial interface never gated by the clock test
			spi_keep_alive_out <= 1'b1;
			// Sticky flags: set wins over clear
			short_circuit_fault_flag_out <= ctrl_r[`SSTC_BIT_SC_CHK] | async_s2_r[0] |
				(short_circuit_fault_flag_out & ~status_clear_in);
			overcurrent_fault_flag_out <= ctrl_r[`SSTC_BIT_OC_CHK] | async_s2_r[1] |
				(overcurrent_fault_flag_out & ~status_clear_in);
			sec_clock_monitor_fault_flag_out <= ctrl_r[`SSTC_BIT_CLK_CHK] | async_s2_r[2] |
				(sec_clock_monitor_fault_flag_out & ~status_clear_in);
			// Manual check always reports, a real mismatch also reports
			sec_config_crc_fault_flag_out <= (crc_done & ctrl_r[`SSTC_BIT_CRC_CHK]) | (crc_done & crc_bad) |
				(sec_config_crc_fault_flag_out & ~status_clear_in);
		end
	end

	// ----------------------------------------
	// Read-back of the control register
	// ----------------------------------------
	always @(posedge mclk_in) begin
		if (rst_in) begin
			reg_rdata_out <= `SSTC_REG_RESET;
		end else if (ce_in) begin
			reg_rdata_out <= ctrl_nxt;
		end
	end

endmodule
`default_nettype wire

// [test/sstc_checker.sv]
// Port assertions for the self-test trigger block
`timescale 1ns/10ps
`default_nettype none
module sstc_checker #(parameter CFG_W = 32, parameter GATE_THRESHOLD_VOLTAGE_CYC = 16) (
	// Clock, reset, enable
	input wire mclk_in,
	input wire rst_in,
	input wire ce_in,
	// Register port
	input wire reg_wr_in,
	input wire [15:0] reg_wdata_in,
	input wire [15:0] reg_rdata_out,
	input wire [1:0] config_sel_in,
	// Trips, flags
	input wire sc_force_trip_out,
	input wire oc_force_trip_out,
	input wire clk_mon_force_out,
	input wire gate_threshold_measure_out,
	input wire short_circuit_fault_flag_out,
	input wire overcurrent_fault_flag_out,
	input wire sec_clock_monitor_fault_flag_out,
	input wire sec_config_crc_fault_flag_out,
	input wire spi_keep_alive_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	int hi_cnt;
	// Length of the running measure window
	always @(posedge mclk_in) hi_cnt <= rst_in ? 0 : (gate_threshold_measure_out ? hi_cnt + 1 : 0);
	sequence s_wr(int b);
		ce_in && reg_wr_in && reg_wdata_in[b];
	endsequence
	sequence s_cfg2;
		config_sel_in == 2'h2;
	endsequence
	property p_sc;
		s_wr(8) |-> ##2 sc_force_trip_out && short_circuit_fault_flag_out;
	endproperty
	property p_oc;
		s_wr(7) |-> ##2 oc_force_trip_out && overcurrent_fault_flag_out;
	endproperty
	property p_clk;
		s_wr(3) |-> ##2 clk_mon_force_out && sec_clock_monitor_fault_flag_out;
	endproperty
	property p_alive;
		s_wr(3) |-> spi_keep_alive_out [*8];
	endproperty
	property p_vg_go;
		s_wr(5) ##0 s_cfg2 |=> reg_rdata_out[5] ##1 gate_threshold_measure_out;
	endproperty
	property p_vg_no;
		s_wr(5) ##0 (config_sel_in != 2'h2 && !reg_rdata_out[5]) |=> !reg_rdata_out[5] ##1 !gate_threshold_measure_out;
	endproperty
	property p_vg_len;
		$fell(gate_threshold_measure_out) |-> hi_cnt == GATE_THRESHOLD_VOLTAGE_CYC;
	endproperty
	property p_crc;
		s_wr(2) |-> ##[3:60] sec_config_crc_fault_flag_out;
	endproperty
	a_sc: assert property (p_sc) else $error("sc trip missing");
	a_oc: assert property (p_oc) else $error("oc trip missing");
	a_clk: assert property (p_clk) else $error("clk fault missing");
	a_alive: assert property (p_alive) else $error("serial stopped");
	a_vg_go: assert property (p_vg_go) else $error("measure not started");
	a_vg_no: assert property (p_vg_no) else $error("measure not refused");
	a_vg_len: assert property (p_vg_len) else $error("measure length wrong");
	a_crc: assert property (p_crc) else $error("crc fault missing");
endmodule
bind sstc_top sstc_checker #(.CFG_W(CFG_W), .GATE_THRESHOLD_VOLTAGE_CYC(GATE_THRESHOLD_VOLTAGE_CYC)) u_chk (
	.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in), .reg_wr_in(reg_wr_in),
	.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .config_sel_in(config_sel_in),
	.sc_force_trip_out(sc_force_trip_out), .oc_force_trip_out(oc_force_trip_out),
	.clk_mon_force_out(clk_mon_force_out), .gate_threshold_measure_out(gate_threshold_measure_out),
	.short_circuit_fault_flag_out(short_circuit_fault_flag_out),
	.overcurrent_fault_flag_out(overcurrent_fault_flag_out),
	.sec_clock_monitor_fault_flag_out(sec_clock_monitor_fault_flag_out),
	.sec_config_crc_fault_flag_out(sec_config_crc_fault_flag_out), .spi_keep_alive_out(spi_keep_alive_out));
`default_nettype wire

// [test/sstc_host_model.sv]
// Host model: device state set up around the latent checks
`timescale 1ns/10ps
`default_nettype none
module sstc_host_model (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic prep_in,
	input wire logic done_in,
	output var logic active_mode_out,
	output var logic config_crc_disable_out,
	output var logic high_side_out
);
	// Prepare before checks, restore CRC after
	always @(posedge mclk_in) begin
		if (rst_in) begin
			active_mode_out <= 1'b0;
			config_crc_disable_out <= 1'b0;
			high_side_out <= 1'b0;
		end else if (prep_in) begin
			active_mode_out <= 1'b1;
			config_crc_disable_out <= 1'b1;
			high_side_out <= 1'b1;
		end else if (done_in) begin
			config_crc_disable_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [test/secondary_selftest_triggers_tb_top.sv]
// Self-checking bench for the self-test trigger block
`timescale 1ns/10ps
`default_nettype none
module secondary_selftest_triggers_tb_top;
	localparam int VG = 4;
	logic mclk_in = 1'b0, rst_in = 1'b1, wr = 1'b0, clr = 1'b0, prep = 1'b0, done = 1'b0;
	logic [15:0] wd = 16'h0000, crc = 16'h1234, rd;
	logic [31:0] img = 32'h5A5A_C3C3;
	logic [1:0] cfg = 2'h0;
	logic act, cdis, hs, sc_f, oc_f, ck_f, gm, scl, ocl, ckl, crcl, alive;
	int errors = 0, n_tests = 0, cyc = 0, n;
	initial forever #5 mclk_in = ~mclk_in;
	// Hang guard
	always @(posedge mclk_in) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors = errors + 1;
			tally_and_finish();
		end
	end
	sstc_host_model host (.mclk_in(mclk_in), .rst_in(rst_in), .prep_in(prep), .done_in(done),
		.active_mode_out(act), .config_crc_disable_out(cdis), .high_side_out(hs));
	sstc_top #(.CFG_W(32), .GATE_THRESHOLD_VOLTAGE_CYC(VG)) dut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1),
		.reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rd), .active_mode_in(act),
		.config_crc_disable_in(cdis), .config_sel_in(cfg), .high_side_output_in(hs),
		.status_clear_in(clr), .sc_cmp_in(1'b0), .oc_cmp_in(1'b0), .clk_mon_fail_in(1'b0),
		.sec_cfg_bits_in(img), .sec_cfg_crc_in(crc), .sc_force_trip_out(sc_f),
		.oc_force_trip_out(oc_f), .clk_mon_force_out(ck_f), .gate_threshold_measure_out(gm),
		.short_circuit_fault_flag_out(scl), .overcurrent_fault_flag_out(ocl),
		.sec_clock_monitor_fault_flag_out(ckl), .sec_config_crc_fault_flag_out(crcl),
		.spi_keep_alive_out(alive));
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// One-cycle write strobe
	task automatic wr_reg(input logic [15:0] d);
		@(posedge mclk_in);
		wr <= 1'b1;
		wd <= d;
		@(posedge mclk_in);
		wr <= 1'b0;
		wd <= 16'h0000;
	endtask
	task automatic step();
		@(posedge mclk_in);
		#1;
	endtask
	task automatic t_sc_oc();
		@(posedge mclk_in);
		prep <= 1'b1;
		@(posedge mclk_in);
		prep <= 1'b0;
		wr_reg(16'h0180);
		step();
		chk("rd_cmd", rd & 16'h0180, 16'h0180);
		step();
		chk("sc", {sc_f, scl}, 16'h0003);
		chk("oc", {oc_f, ocl}, 16'h0003);
		repeat (3) @(posedge mclk_in);
		clr <= 1'b1;
		@(posedge mclk_in);
		clr <= 1'b0;
		step();
		chk("cleared", {scl, ocl}, 16'h0000);
	endtask
	task automatic t_clk();
		wr_reg(16'h0048);
		wr_reg(16'h0010);
		#1;
		chk("clk", {ck_f, ckl}, 16'h0003);
		step();
		chk("rd_live", rd & 16'h0050, 16'h0010);
		chk("alive", alive, 16'h0001);
	endtask
	task automatic t_gate_threshold_voltage();
		@(posedge mclk_in);
		cfg <= 2'h1;
		wr_reg(16'h0020);
		step();
		chk("vg_rd_no", rd & 16'h0020, 16'h0000);
		step();
		chk("vg_no", gm, 16'h0000);
		@(posedge mclk_in);
		cfg <= 2'h2;
		wr_reg(16'h0020);
		step();
		chk("vg_go", gm, 16'h0001);
		n = 0;
		while (gm && n < 100) begin
			step();
			n++;
		end
		chk("vg_len", 16'(n), 16'(VG));
	endtask
	task automatic t_crc();
		wr_reg(16'h0004);
		n = 0;
		while (!crcl && n < 60) begin
			step();
			n++;
		end
		chk("crc", crcl, 16'h0001);
		@(posedge mclk_in);
		done <= 1'b1;
		@(posedge mclk_in);
		done <= 1'b0;
	endtask
	initial begin
		repeat (4) @(posedge mclk_in);
		rst_in <= 1'b0;
		step();
		chk("rst_rd", rd, 16'h0000);
		chk("rst_out", {alive, scl, ocl, ckl, crcl, gm}, 16'h0020);
		t_sc_oc();
		t_clk();
		t_gate_threshold_voltage();
		t_crc();
		tally_and_finish();
	end
endmodule
`default_nettype wire
